// file: shared/pbd_pkg.sv
// Constants and types for the bank clock divider.
// Assumes one core clock standing in for the oscillator; no bus, plain ports only.
// Functional notes
// - Divide the oscillator by two and four, both references at half duty.
// - Selects pick which of banks one to three carry the quarter-rate reference.
// - Gate high forces every clock output low; gate low lets them toggle.
// - Falling edge of clear restarts the quarter-rate reference phase.
// - Bypass high routes the reference input around the loop to the outputs.
// - Bypass low means outputs come through the loop; high is test mode.
// - Feeding back a half-rate output puts the oscillator at twice the input.
// - Oscillator spans 100 MHz to 200 MHz, twice the output range.
// - Outside bypass, every output clock has half duty whatever the input duty.
package pbd_pkg;
   localparam int PBD_BANKS = 4;
   localparam int PBD_PER_BANK = 3;
   localparam int PBD_CNT_W = 2;
   localparam logic [1:0] PBD_CNT_RST = 2'h0;
   localparam int PBD_HALF_BIT = 0;
   localparam int PBD_QUARTER_BIT = 1;
   localparam int PBD_VCO_MIN_MHZ = 100;
   localparam int PBD_VCO_MAX_MHZ = 200;
   localparam int PBD_CORE_MHZ = 10;
   typedef enum logic [1:0] {PBD_SEL_NONE, PBD_SEL_ONE, PBD_SEL_TWO, PBD_SEL_THREE} pbd_sel_e;
endpackage

// file: shared/pbd_ref_if.sv
// Carries the two divided references between divider and bank mux.
// Assumes both ends share the core clock.
`timescale 1ns/1ns
`default_nettype none
interface pbd_ref_if;
   logic half_ref;
   logic quarter_ref;
   modport src (output half_ref, output quarter_ref);
   modport dst (input half_ref, input quarter_ref);
endinterface
`default_nettype wire

// file: hw/pbd_ref_divider.sv
// Shared counter that produces the half and quarter references.
// Assumes the core clock stands in for the oscillator.
`timescale 1ns/1ns
`default_nettype none
module pbd_ref_divider
   import pbd_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_quarter_restart,
   pbd_ref_if.src o_refs
);
   logic [PBD_CNT_W-1:0] cnt_r;
   // One counter feeds both taps, so the quarter edge lands on a half edge except when a clear restarts the count.
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cnt_r <= PBD_CNT_RST;
      else if (i_quarter_restart)
         cnt_r <= PBD_CNT_RST;
      else
         cnt_r <= cnt_r + 2'h1;
   end
   // The half tap is inverted so that it rises on the same edge as the quarter tap.
   assign o_refs.half_ref = ~cnt_r[PBD_HALF_BIT];
   assign o_refs.quarter_ref = cnt_r[PBD_QUARTER_BIT];

   AST_QUARTER_PERIOD: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!i_quarter_restart [*5]) |-> (cnt_r == $past(cnt_r, 4)))
      else $error("Quarter reference period is not four cycles.");
endmodule
`default_nettype wire

// file: hw/pbd_bank_clock_top.sv
// Top of the bank clock divider: selection, gating, clear and bypass.
// Assumes the core clock is the oscillator and all pins are synchronous to it.
`timescale 1ns/1ns
`default_nettype none
module pbd_bank_clock_top
   import pbd_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_ref_clock_in,
   input wire logic i_loop_feedback_in,
   input wire logic i_bank_select_hi,
   input wire logic i_bank_select_lo,
   input wire logic i_output_gate_n,
   input wire logic i_quarter_divider_clear_n,
   input wire logic i_bypass,
   output logic [PBD_PER_BANK-1:0] o_bank1_clock_out,
   output logic [PBD_PER_BANK-1:0] o_bank2_clock_out,
   output logic [PBD_PER_BANK-1:0] o_bank3_clock_out,
   output logic [PBD_PER_BANK-1:0] o_bank4_clock_out,
   output logic o_feedback_seen
);
   pbd_ref_if refs();
   logic clr_d_r;
   logic clr_fall;
   logic fb_d_r;
   logic [PBD_BANKS-1:0] bank_r;
   logic [PBD_BANKS-1:0] bank_nxt;

   // Quarter-rate usage per bank from the selects; bank four never joins.
   function automatic logic [PBD_BANKS-1:0] quarter_map(input logic hi, input logic lo);
      pbd_sel_e s;
      s = pbd_sel_e'({hi, lo});
      case (s)
         PBD_SEL_NONE: quarter_map = 4'h0;
         PBD_SEL_ONE: quarter_map = 4'h1;
         PBD_SEL_TWO: quarter_map = 4'h3;
         default: quarter_map = 4'h7;
      endcase
   endfunction

   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         clr_d_r <= 1'b0;
      else
         clr_d_r <= i_quarter_divider_clear_n;
   end
   assign clr_fall = clr_d_r && !i_quarter_divider_clear_n;

   pbd_ref_divider u_div (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_quarter_restart(clr_fall),
      .o_refs(refs)
   );

   always_comb
   begin
      logic [PBD_BANKS-1:0] qm;
      qm = quarter_map(i_bank_select_hi, i_bank_select_lo);
      for (int b = 0; b < PBD_BANKS; b++)
         bank_nxt[b] = qm[b] ? refs.quarter_ref : refs.half_ref;
      // Test mode skips the loop and passes the reference straight through.
      if (i_bypass)
         bank_nxt = {PBD_BANKS{i_ref_clock_in}};
      if (i_output_gate_n)
         bank_nxt = '0;
   end

   // Registering the outputs costs one cycle but keeps them glitch free.
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         bank_r <= '0;
      else
         bank_r <= bank_nxt;
   end

   // Feedback is only observed here; the loop itself is analog and lies outside.
   always_ff @(posedge i_core_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         fb_d_r <= 1'b0;
      else
         fb_d_r <= i_loop_feedback_in;
   end

   assign o_bank1_clock_out = {PBD_PER_BANK{bank_r[0]}};
   assign o_bank2_clock_out = {PBD_PER_BANK{bank_r[1]}};
   assign o_bank3_clock_out = {PBD_PER_BANK{bank_r[2]}};
   assign o_bank4_clock_out = {PBD_PER_BANK{bank_r[3]}};
   assign o_feedback_seen = fb_d_r;

   // Named steps shared by the properties below.
   sequence s_live;
      !i_output_gate_n && !i_bypass;
   endsequence

   sequence s_quarter_rise;
      $rose(refs.quarter_ref);
   endsequence

   sequence s_no_clear_two;
      !clr_fall [*2];
   endsequence

   // A second clear inside the settle window restarts the count, so it is excluded.
   sequence s_clear_settle;
      clr_fall ##1 s_no_clear_two;
   endsequence

   AST_GATE_LOW: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      i_output_gate_n |=> (bank_r == 4'h0))
      else $error("Outputs not low while gated.");
   AST_BANK4_HALF: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!i_output_gate_n && !i_bypass) |=> (bank_r[3] == $past(refs.half_ref)))
      else $error("Bank four not on half reference.");
   AST_SEL_QUARTER: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!i_output_gate_n && !i_bypass && i_bank_select_hi && i_bank_select_lo)
      |=> (bank_r[2] == $past(refs.quarter_ref)))
      else $error("Bank three not on quarter reference.");
   AST_SEL_NONE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!i_output_gate_n && !i_bypass && !i_bank_select_hi && !i_bank_select_lo)
      |=> (bank_r[0] == $past(refs.half_ref)))
      else $error("Bank one not on half reference.");
   AST_BYPASS: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!i_output_gate_n && i_bypass) |=> (bank_r[1] == $past(i_ref_clock_in)))
      else $error("Bypass does not pass the reference.");
   AST_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      clr_fall |=> !refs.quarter_ref)
      else $error("Clear did not restart quarter phase.");

   AST_CLEAR_RISE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      s_clear_settle |=> refs.quarter_ref)
      else $error("Quarter reference not high two cycles after clear.");
   AST_ALIGN: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      $rose(refs.quarter_ref) |-> $rose(refs.half_ref))
      else $error("Quarter edge not aligned with half edge.");
   AST_HALF_TOGGLE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      !clr_fall |=> (refs.half_ref != $past(refs.half_ref)))
      else $error("Half reference does not toggle.");

   AST_SEL_ONE_B1: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (!i_bank_select_hi && i_bank_select_lo)) |=> (bank_r[0] == $past(refs.quarter_ref)))
      else $error("Bank one not on quarter reference for select one.");

   AST_SEL_ONE_B2: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (!i_bank_select_hi && i_bank_select_lo)) |=> (bank_r[1] == $past(refs.half_ref)))
      else $error("Bank two not on half reference for select one.");

   AST_SEL_ONE_B3: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (!i_bank_select_hi && i_bank_select_lo)) |=> (bank_r[2] == $past(refs.half_ref)))
      else $error("Bank three not on half reference for select one.");

   AST_SEL_TWO_B1: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (i_bank_select_hi && !i_bank_select_lo)) |=> (bank_r[0] == $past(refs.quarter_ref)))
      else $error("Bank one not on quarter reference for select two.");

   AST_SEL_TWO_B2: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (i_bank_select_hi && !i_bank_select_lo)) |=> (bank_r[1] == $past(refs.quarter_ref)))
      else $error("Bank two not on quarter reference for select two.");

   AST_SEL_TWO_B3: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (i_bank_select_hi && !i_bank_select_lo)) |=> (bank_r[2] == $past(refs.half_ref)))
      else $error("Bank three not on half reference for select two.");

   AST_SEL_THREE_B1: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (i_bank_select_hi && i_bank_select_lo)) |=> (bank_r[0] == $past(refs.quarter_ref)))
      else $error("Bank one not on quarter reference for select three.");

   AST_SEL_THREE_B2: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (i_bank_select_hi && i_bank_select_lo)) |=> (bank_r[1] == $past(refs.quarter_ref)))
      else $error("Bank two not on quarter reference for select three.");

   AST_SEL_NONE_B2: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (!i_bank_select_hi && !i_bank_select_lo)) |=> (bank_r[1] == $past(refs.half_ref)))
      else $error("Bank two not on half reference for select none.");

   AST_SEL_NONE_B3: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (!i_bank_select_hi && !i_bank_select_lo)) |=> (bank_r[2] == $past(refs.half_ref)))
      else $error("Bank three not on half reference for select none.");

   AST_BANK4_SEL: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_live ##0 (i_bank_select_hi && i_bank_select_lo)) |=> (bank_r[3] == $past(refs.half_ref)))
      else $error("Bank four left the half reference.");

   AST_BYPASS_ALL: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (!i_output_gate_n && i_bypass) |=> (bank_r == {PBD_BANKS{$past(i_ref_clock_in)}}))
      else $error("Bypass does not reach every bank.");

   AST_GATE_BYPASS: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (i_output_gate_n && i_bypass) |=> (bank_r == 4'h0))
      else $error("Gate does not override bypass.");

   AST_GATE_PINS: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      i_output_gate_n |=> ((o_bank1_clock_out | o_bank2_clock_out | o_bank3_clock_out | o_bank4_clock_out) == 3'h0))
      else $error("A clock pin is high while gated.");

   AST_UNGATE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      ($fell(i_output_gate_n) ##0 !i_bypass) |=> (bank_r[3] == $past(refs.half_ref)))
      else $error("Outputs do not resume after the gate opens.");

   AST_QUARTER_HIGH: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_quarter_rise ##0 !clr_fall) |=> refs.quarter_ref)
      else $error("Quarter reference high for less than two cycles.");

   AST_QUARTER_LOW: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      (s_quarter_rise ##0 s_no_clear_two) |=> !refs.quarter_ref)
      else $error("Quarter reference high for more than two cycles.");

   AST_HALF_DUTY: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
      ($rose(refs.half_ref) ##0 !clr_fall) |=> !refs.half_ref)
      else $error("Half reference high for more than one cycle.");
endmodule
`default_nettype wire

// file: tb/pbd_board_model.sv
// Board model: reference clock source and the feedback wire.
// Assumes one block output is handed in as the feedback source.
`timescale 1ns/1ns
`default_nettype none
module pbd_board_model
(
   input wire logic i_core_clk,
   input wire logic i_fb_src,
   output logic o_ref_clock_in,
   output logic o_loop_feedback_in
);
   initial o_ref_clock_in = 1'b0;
   // Bank four is fed back, so the reference runs at the half rate of the core clock.
   always @(negedge i_core_clk) o_ref_clock_in <= ~o_ref_clock_in;
   // Exactly one output closes the loop; a second wire would fight it.
   assign o_loop_feedback_in = i_fb_src;
endmodule
`default_nettype wire

// file: tb/tb_pbd_bank_clock_top.sv
// Self-checking bench for the bank clock divider.
// Assumes a lockstep model of the divider; inputs change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb_pbd_bank_clock_top;
   import pbd_pkg::*;
   logic clk, rst_n, sel_hi, sel_lo, gate_n, clr_n, byp, refc, fb, seen, fb_q, prev_clr;
   logic [2:0] b1, b2, b3, b4;
   logic [1:0] cnt;
   logic [11:0] exp_v;
   int n_mismatch = 0;
   int cmp_count = 0;
   task automatic cmp(input logic [12:0] got, input logic [12:0] want);
      cmp_count++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic run(input string name, input logic [4:0] v, input int n);
      @(negedge clk);
      {sel_hi, sel_lo, gate_n, clr_n, byp} = v;
      repeat (n) @(negedge clk);
      $display("test %s done", name);
   endtask
   // Bank four sits above every select value, so unless gated or bypassed it takes the half-rate bit.
   function automatic logic [2:0] bank_exp(input int b);
      if (gate_n)
         return 3'h0;
      if (byp)
         return {3{refc}};
      return {3{(b <= int'({sel_hi, sel_lo})) ? cnt[1] : ~cnt[0]}};
   endfunction
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         cnt <= 2'h0;
         exp_v <= 12'h000;
         fb_q <= 1'b0;
         prev_clr <= 1'b0;
      end
      else
      begin
         exp_v <= {bank_exp(1), bank_exp(2), bank_exp(3), bank_exp(4)};
         cnt <= (prev_clr && !clr_n) ? 2'h0 : cnt + 2'h1;
         fb_q <= fb;
         prev_clr <= clr_n;
      end
   always @(negedge clk)
      if (rst_n)
         cmp({b1, b2, b3, b4, seen}, {exp_v, fb_q});
   pbd_bank_clock_top u_pbd_bank_clock_top (.i_core_clk(clk), .i_arst_n(rst_n), .i_ref_clock_in(refc),
      .i_loop_feedback_in(fb), .i_bank_select_hi(sel_hi), .i_bank_select_lo(sel_lo), .i_output_gate_n(gate_n),
      .i_quarter_divider_clear_n(clr_n), .i_bypass(byp), .o_bank1_clock_out(b1), .o_bank2_clock_out(b2),
      .o_bank3_clock_out(b3), .o_bank4_clock_out(b4), .o_feedback_seen(seen));
   pbd_board_model u_pbd_board_model (.i_core_clk(clk), .i_fb_src(b4[0]), .o_ref_clock_in(refc),
      .o_loop_feedback_in(fb));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      {rst_n, sel_hi, sel_lo, gate_n, clr_n, byp} = 6'b000010;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      for (int s = 0; s < 4; s++)
         run("select", {s[1:0], 3'b010}, 12);
      run("gate", 5'b11110, 6);
      run("bypass", 5'b00011, 6);
      run("gate_over_bypass", 5'b00111, 4);
      run("clear", 5'b10000, 5);
      run("clear_release", 5'b10010, 1);
      run("clear_again", 5'b10000, 6);
      tally_and_finish();
   end
endmodule
`default_nettype wire
